// ==== logic/tvb_trip_vote.sv ====
// Purpose: Coincidence voting, channel bypass and manual range blocks for a trip output.
// Assumes: Demands, permissives and monitor data come from channel logic on clk_in;
//          operator switches (manual trip, injection trip, bypass, block) are asynchronous.
// Notes:   The trip output latches until rst_n_in; software only sees, masks and clears events.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "tvb_map.svh"

// What this block does
// [R1] Manual range block request is taken only while the P-10 permissive is active.
// [R2] An active range block drops by itself when the P-10 permissive goes away.
// [R3] Each channel set has its own block control for each blockable range trip.
// [R4] Manual and injection trips cannot be bypassed; bypass only touches other channels.
// [R5] One bypassed channel: remaining channels vote two of three, indefinitely.
// [R6] Two bypassed channels: remaining channels vote one of two, indefinitely.
// [R7] Three or more bypass requests on one function force a trip.
// [R8] A channel under on-line test is bypassed without any manual command.
// [R9] Maintenance staff bypass a channel manually before servicing it.
// [R10] Each loop hot-leg power signal is the average of its two opposed monitors.
// [R11] Every trip function takes four redundant channel demands, one per channel set.
// [R12] With no bypass, two of four active demands trip the function.
// [R13] Removing a bypass returns voting to the coincidence for the bypasses left.
// [R14] Bypass never alters setpoints; only the coincidence vote changes.
// [R15] Four excore detectors each deliver four vertical section signals.
// [R16] Vote every cycle; registered trip output stays set until reset.
module tvb_trip_vote
  import tvb_pkg::*;
#(
  parameter int NUM_FUNC = 4,   // Bypassable trip functions.
  parameter int NUM_LOOP = 4,   // Coolant loops.
  parameter int DATA_W   = 12   // Monitor and detector sample width.
) (
  input  wire logic                     clk_in,          // 20 MHz clock.
  input  wire logic                     rst_n_in,        // Synchronous reset, active low.
  input  wire logic [NUM_FUNC*4-1:0]    demand_in,       // Channel demands, 4 per function.
  input  wire logic [NUM_FUNC*4-1:0]    bypass_req_in,   // Manual bypass switches.
  input  wire logic [3:0]               online_test_in,  // Channel set under on-line test.
  input  wire logic [3:0]               ir_demand_in,    // Intermediate range demands.
  input  wire logic [3:0]               prl_demand_in,   // Power range low demands.
  input  wire logic [3:0]               ir_block_req_in, // Intermediate block switches.
  input  wire logic [3:0]               prl_block_req_in,// Power range low block switches.
  input  wire logic [3:0]               p10_in,          // P-10 permissive per channel set.
  input  wire logic [1:0]               manual_trip_in,  // Manual trip switches.
  input  wire logic [1:0]               si_trip_in,      // Injection trip switches.
  input  wire logic [NUM_LOOP*DATA_W-1:0] n16_a_in,      // First hot-leg monitor per loop.
  input  wire logic [NUM_LOOP*DATA_W-1:0] n16_b_in,      // Opposed hot-leg monitor per loop.
  input  wire logic [16*DATA_W-1:0]     axial_in,        // 4 detectors x 4 sections.
  input  wire logic [`TVB_ADDR_W-1:0]   addr_in,         // Register byte address.
  input  wire logic [31:0]              wr_data_in,      // Register write data.
  input  wire logic                     wr_in,           // Write strobe.
  input  wire logic                     rd_in,           // Read strobe.
  output logic [31:0]                   rd_data_out,     // Read data, cycle after rd_in.
  output logic                          trip_out,        // Latched trip demand.
  output logic                          irq_out,         // Enabled event pending.
  output logic [3:0]                    ir_block_out,    // Intermediate blocks in force.
  output logic [3:0]                    prl_block_out,   // Power range low blocks in force.
  output logic [NUM_LOOP*DATA_W-1:0]    n16_avg_out,     // Hot-leg average per loop.
  output logic [16*DATA_W-1:0]          axial_out        // Registered section signals.
);

  localparam int SW = NUM_FUNC * 4 + 12;

  initial begin
    if (NUM_FUNC < 1 || NUM_LOOP < 1 || DATA_W < 1 || DATA_W > 30) begin
      $error("tvb_trip_vote: unsupported parameter values");
    end
  end

  // Counts the bypassed channels of one function.
  function automatic tvb_cnt_t byp_count(input logic [3:0] byp);
    byp_count = tvb_cnt_t'(byp[0]) + tvb_cnt_t'(byp[1]) + tvb_cnt_t'(byp[2])
              + tvb_cnt_t'(byp[3]);
  endfunction : byp_count

  // Coincidence vote: the demand count needed shrinks as channels leave the vote.
  function automatic logic vote(input logic [3:0] dem, input logic [3:0] byp);
    tvb_cnt_t nb;
    tvb_cnt_t nd;
    nb = byp_count(byp);
    nd = byp_count(dem & ~byp);
    if (nb >= 3'd3) begin
      vote = 1'b1;                                         // [R7]
    end else if (nb == 3'd2) begin
      vote = (nd >= 3'd1);                                 // [R6]
    end else begin
      vote = (nd >= 3'd2);                                 // [R5] [R12] [R13]
    end
  endfunction : vote

  // Switches pass three flops; a set is taken once stages two and three agree, a release as soon as they differ.
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] sync3;
  logic [SW-1:0] sw;
  wire  [SW-1:0] raw_sw = {bypass_req_in, ir_block_req_in, prl_block_req_in,
                           manual_trip_in, si_trip_in};

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      sw    <= '0;
    end else begin
      sync1 <= raw_sw;
      sync2 <= sync1;
      sync3 <= sync2;
      sw    <= (sw & ~(sync2 ^ sync3)) | (sync2 & ~(sync2 ^ sync3));
    end
  end

  wire [NUM_FUNC*4-1:0] byp_sw   = sw[SW-1:12];
  wire [3:0]            ir_req   = sw[11:8];
  wire [3:0]            prl_req  = sw[7:4];
  wire [1:0]            man_trip = sw[3:2];
  wire [1:0]            si_trip  = sw[1:0];

  // Per-channel-set range blocks.
  logic [3:0] ir_blk;
  logic [3:0] prl_blk;
  logic [3:0] ir_req_q;
  logic [3:0] prl_req_q;
  wire  [3:0] next_ir_blk  = (ir_blk | ir_req) & p10_in;             // [R1] [R2] [R3]
  wire  [3:0] next_prl_blk = (prl_blk | prl_req) & p10_in;           // [R1] [R2] [R3]
  wire  [3:0] req_rise     = (ir_req & ~ir_req_q) | (prl_req & ~prl_req_q);
  wire        blk_refused  = |(req_rise & ~p10_in);                  // [R1]
  wire        blk_dropped  = |((ir_blk | prl_blk) & ~p10_in);        // [R2]

  // Range trips vote 2 of 4 with blocked channels simply not demanding.
  wire ir_trip  = vote(ir_demand_in & ~ir_blk, 4'h0);                // [R14]
  wire prl_trip = vote(prl_demand_in & ~prl_blk, 4'h0);

  // Effective bypass per function: manual switch or on-line test.
  logic [NUM_FUNC-1:0] func_trip;
  logic [NUM_FUNC-1:0] func_excess;
  genvar gf;
  generate
    for (gf = 0; gf < NUM_FUNC; gf++) begin : g_func
      wire [3:0] byp_eff = byp_sw[gf*4 +: 4] | online_test_in;       // [R8] [R9]
      assign func_trip[gf]   = vote(demand_in[gf*4 +: 4], byp_eff);  // [R11]
      assign func_excess[gf] = (byp_count(byp_eff) >= 3'd3);         // [R7]
    end
  endgenerate

  // Manual and injection trips enter past the bypass logic.
  wire any_trip  = (|func_trip) | ir_trip | prl_trip | (|man_trip) | (|si_trip); // [R4]
  wire next_trip = trip_out | any_trip;                              // [R16]

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      trip_out      <= 1'b0;
      ir_blk        <= 4'h0;
      prl_blk       <= 4'h0;
      ir_req_q      <= 4'h0;
      prl_req_q     <= 4'h0;
      ir_block_out  <= 4'h0;
      prl_block_out <= 4'h0;
    end else begin
      trip_out      <= next_trip;                                    // [R16]
      ir_blk        <= next_ir_blk;
      prl_blk       <= next_prl_blk;
      ir_req_q      <= ir_req;
      prl_req_q     <= prl_req;
      ir_block_out  <= next_ir_blk;
      prl_block_out <= next_prl_blk;
    end
  end

  // Monitor averaging and detector capture.
  logic [NUM_LOOP*DATA_W-1:0] next_avg;
  genvar gl;
  generate
    for (gl = 0; gl < NUM_LOOP; gl++) begin : g_loop
      wire [DATA_W:0] sum = {1'b0, n16_a_in[gl*DATA_W +: DATA_W]}
                          + {1'b0, n16_b_in[gl*DATA_W +: DATA_W]};
      assign next_avg[gl*DATA_W +: DATA_W] = sum[DATA_W:1];          // [R10]
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      n16_avg_out <= '0;
      axial_out   <= '0;
    end else begin
      n16_avg_out <= next_avg;
      axial_out   <= axial_in;                                       // [R15]
    end
  end

  // Register port: events are sticky, a set in the clear cycle wins.
  logic [`TVB_EV_W-1:0] status;
  logic [`TVB_EV_W-1:0] enable;
  logic [`TVB_EV_W-1:0] events;
  assign events[`TVB_EV_TRIP]       = next_trip & ~trip_out;
  assign events[`TVB_EV_BYP_EXCESS] = |func_excess;
  assign events[`TVB_EV_BLK_REFUSE] = blk_refused;
  assign events[`TVB_EV_BLK_DROP]   = blk_dropped;

  tvb_sel_t sel;
  assign sel = (addr_in == `TVB_OFS_STATUS) ? TVB_SEL_STATUS :
               (addr_in == `TVB_OFS_ENABLE) ? TVB_SEL_ENABLE :
               (addr_in == `TVB_OFS_STATE)  ? TVB_SEL_STATE  : TVB_SEL_NONE;
  wire clr_hit = wr_in && (addr_in == `TVB_OFS_CLEAR);
  wire en_hit  = wr_in && (addr_in == `TVB_OFS_ENABLE);
  wire [`TVB_EV_W-1:0] clr_bits = clr_hit ? wr_data_in[`TVB_EV_W-1:0] : '0;
  wire [`TVB_EV_W-1:0] next_status = (status & ~clr_bits) | events;
  wire [`TVB_EV_W-1:0] next_enable = en_hit ? wr_data_in[`TVB_EV_W-1:0] : enable;

  logic [31:0] state_word;
  always_comb begin
    state_word = `TVB_RST_DATA;
    state_word[`TVB_ST_TRIP] = trip_out;
    state_word[`TVB_ST_IR_LSB +: 4]  = ir_blk;
    state_word[`TVB_ST_PRL_LSB +: 4] = prl_blk;
  end

  wire [31:0] read_mux =
      ({32{sel == TVB_SEL_STATUS}} & {{(32-`TVB_EV_W){1'b0}}, status}) |
      ({32{sel == TVB_SEL_ENABLE}} & {{(32-`TVB_EV_W){1'b0}}, enable}) |
      ({32{sel == TVB_SEL_STATE}}  & state_word);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      status      <= `TVB_RST_EVENTS;
      enable      <= `TVB_RST_ENABLE;
      rd_data_out <= `TVB_RST_DATA;
      irq_out     <= 1'b0;
    end else begin
      status      <= next_status;
      enable      <= next_enable;
      rd_data_out <= rd_in ? read_mux : `TVB_RST_DATA;
      irq_out     <= |(next_status & next_enable);
    end
  end

  // Checks.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_trip_latch_holds: assert property (trip_out |=> trip_out)   // [R16]
    else $error("trip output dropped without reset");
  a_excess_forces_trip: assert property ((|func_excess) |=> trip_out)   // [R7]
    else $error("three bypasses did not trip");
  a_block_needs_p10: assert property (!$past(p10_in[0]) |-> !ir_blk[0] && !prl_blk[0]) // [R1]
    else $error("block held without permissive");
  a_block_auto_drop: assert property (ir_blk[1] && !p10_in[1] |=> !ir_blk[1])   // [R2]
    else $error("intermediate block not removed below permissive");
  a_block_independent: assert property (
      $rose(ir_blk[2]) |-> $past(ir_req[2]) || ir_req[2])   // [R3]
    else $error("block set without its own request");
  a_manual_trip_direct: assert property ((|man_trip) |=> trip_out)   // [R4]
    else $error("manual trip suppressed");
  a_two_of_three: assert property (
      byp_count(byp_sw[3:0] | online_test_in) == 3'd1
      && byp_count(demand_in[3:0] & ~(byp_sw[3:0] | online_test_in)) == 3'd2
      |=> trip_out)   // [R5]
    else $error("two of three vote missed");
  a_one_of_two: assert property (
      byp_count(byp_sw[3:0] | online_test_in) == 3'd2 && !trip_out
      |-> !(|(demand_in[3:0] & ~(byp_sw[3:0] | online_test_in))) || func_trip[0])   // [R6]
    else $error("one of two vote missed");
  a_single_no_trip: assert property (
      byp_count(byp_sw[3:0] | online_test_in) == 3'd0
      && byp_count(demand_in[3:0]) == 3'd1 |-> !func_trip[0])   // [R12]
    else $error("single demand tripped a full vote");
  a_test_bypass: assert property (
      online_test_in == 4'h1 && byp_sw[3:0] == 4'h0 |-> func_trip[0] ==
      (byp_count(demand_in[3:1]) >= 3'd2))   // [R8]
    else $error("on-line test did not bypass channel");
  a_average_loop: assert property (
      n16_avg_out[DATA_W-1:0] ==
      DATA_W'(({1'b0, $past(n16_a_in[DATA_W-1:0])} + {1'b0, $past(n16_b_in[DATA_W-1:0])}) >> 1)
      || $past(!rst_n_in))   // [R10]
    else $error("hot-leg average wrong");
  a_read_one_cycle: assert property (!$past(rd_in) |-> rd_data_out == `TVB_RST_DATA)
    else $error("read data outside its cycle");

  c_trip_seen: cover property ($rose(trip_out));
  c_block_set: cover property ($rose(ir_blk[0]));
  c_block_drop: cover property ($fell(prl_blk[3]));
  c_two_bypass: cover property (byp_count(byp_sw[3:0] | online_test_in) == 3'd2);

endmodule : tvb_trip_vote

// ==== logic/tvb_map.svh ====
// Purpose: Register offsets, field positions and reset values of the trip vote block.
// Assumes: Byte addresses on an 8-bit register port with 32-bit data.
// Notes:   Definitions only; included by the design module and the bench.
`ifndef TVB_MAP_SVH
`define TVB_MAP_SVH
`define TVB_ADDR_W        8
`define TVB_OFS_STATUS    8'h00
`define TVB_OFS_CLEAR     8'h04
`define TVB_OFS_ENABLE    8'h08
`define TVB_OFS_STATE     8'h0C
`define TVB_EV_W          4
`define TVB_EV_TRIP       0
`define TVB_EV_BYP_EXCESS 1
`define TVB_EV_BLK_REFUSE 2
`define TVB_EV_BLK_DROP   3
`define TVB_ST_TRIP       0
`define TVB_ST_IR_LSB     4
`define TVB_ST_PRL_LSB    8
`define TVB_RST_EVENTS    4'h0
`define TVB_RST_ENABLE    4'h0
`define TVB_RST_DATA      32'h0000_0000
`endif

// ==== logic/tvb_pkg.sv ====
// Purpose: Types used by the trip vote block and its checks.
// Assumes: Constants come from tvb_map.svh.
// Notes:   Register select is one-hot so the read mux is a plain AND-OR.
package tvb_pkg;
  typedef logic [2:0] tvb_cnt_t;
  typedef enum logic [3:0] {
    TVB_SEL_STATUS = 4'h1,
    TVB_SEL_ENABLE = 4'h2,
    TVB_SEL_STATE  = 4'h4,
    TVB_SEL_NONE   = 4'h8
  } tvb_sel_t;
endpackage : tvb_pkg

// ==== test/tvb_chan_model.sv ====
// Purpose: Behavioural channel sets and maintenance switches facing the trip vote block.
// Assumes: Commands from the bench change just after a rising edge.
// Notes:   A channel under repair gives noisy demands, as loose electronics would.
`timescale 1ns/100ps
module tvb_chan_model (
  input  wire logic        clk_in,      // Block clock.
  input  wire logic [15:0] dem_cmd_in,  // Wanted channel demands.
  input  wire logic [15:0] byp_cmd_in,  // Wanted manual bypasses.
  input  wire logic [3:0]  svc_cmd_in,  // Channel sets under repair.
  input  wire logic [3:0]  test_cmd_in, // Channel sets under on-line test.
  input  wire logic [3:0]  p10_cmd_in,  // Permissive per channel set.
  output logic      [15:0] demand_out,  // Channel demands.
  output logic      [15:0] bypass_out,  // Bypass switches.
  output logic      [3:0]  test_out,    // On-line test flags.
  output logic      [3:0]  p10_out      // Permissive per channel set.
);
  logic        tog = 1'b0;
  logic [15:0] next_bypass;
  // Noise starts one cycle after the repair command, while the bypass still passes the
  // switch filter, so a bench keeps the demands of the other channel sets low meanwhile.
  assign next_bypass = byp_cmd_in | {4{svc_cmd_in}};
  always_ff @(posedge clk_in) begin
    tog        <= ~tog;
    demand_out <= dem_cmd_in ^ ({4{svc_cmd_in}} & {16{tog}});
    bypass_out <= next_bypass;
    test_out   <= test_cmd_in;
    p10_out    <= p10_cmd_in;
  end
endmodule : tvb_chan_model

// ==== test/trip_vote_bypass_logic_bench.sv ====
// Purpose: Self-checking bench for the trip vote block.
// Assumes: Default widths; switch inputs settle within eight cycles.
// Notes:   Trip latches, so each vote case starts from a fresh reset.
`timescale 1ns/100ps
`include "tvb_map.svh"
module trip_vote_bypass_logic_bench;
  logic         clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  logic [15:0]  dem_cmd = '0, byp_cmd = '0, demand, bypass;
  logic [3:0]   svc_cmd = '0, test_cmd = '0, p10_cmd = '0, online_test, p10;
  logic [3:0]   ir_dem = '0, prl_dem = '0, ir_req = '0, prl_req = '0, ir_blk, prl_blk;
  logic [1:0]   man = '0, si = '0;
  logic [47:0]  n_a = '0, n_b = '0, n_avg;
  logic [191:0] ax = '0, ax_q;
  logic [7:0]   addr = '0;
  logic [31:0]  wdata = '0, rdata;
  logic         wr = 1'b0, rd = 1'b0, trip, irq;
  int           n_errors = 0, checks_done = 0;

  always #25 clk_in = ~clk_in;

  tvb_chan_model u_tvb_chan_model (.clk_in(clk_in), .dem_cmd_in(dem_cmd), .byp_cmd_in(byp_cmd),
    .svc_cmd_in(svc_cmd), .test_cmd_in(test_cmd), .p10_cmd_in(p10_cmd), .demand_out(demand),
    .bypass_out(bypass), .test_out(online_test), .p10_out(p10));

  tvb_trip_vote #(.NUM_FUNC(4), .NUM_LOOP(4), .DATA_W(12)) u_tvb_trip_vote (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .demand_in(demand), .bypass_req_in(bypass), .online_test_in(online_test),
    .ir_demand_in(ir_dem), .prl_demand_in(prl_dem), .ir_block_req_in(ir_req),
    .prl_block_req_in(prl_req), .p10_in(p10), .manual_trip_in(man), .si_trip_in(si),
    .n16_a_in(n_a), .n16_b_in(n_b), .axial_in(ax), .addr_in(addr), .wr_data_in(wdata),
    .wr_in(wr), .rd_in(rd), .rd_data_out(rdata), .trip_out(trip), .irq_out(irq),
    .ir_block_out(ir_blk), .prl_block_out(prl_blk), .n16_avg_out(n_avg), .axial_out(ax_q));

  task automatic chk(input string name, input logic [191:0] exp, input logic [191:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  task automatic do_reset;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    {dem_cmd, byp_cmd, svc_cmd, test_cmd, man, si, ir_req, prl_req, ir_dem, prl_dem} <= '0;
    cyc(4);
    rst_n_in <= 1'b1;
  endtask : do_reset

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk(name, exp, rdata);
  endtask : rd_chk

  // Bypass and test go in first, so the vote under test is settled before demands arrive.
  task automatic vote_case(input int f, input logic [3:0] byp, input logic [3:0] tst,
                           input logic [3:0] dem, input logic [3:0] sw, input logic exp);
    do_reset;
    byp_cmd  <= 16'(byp) << (4 * f);
    test_cmd <= tst;
    {si, man} <= sw;
    cyc(8);
    dem_cmd <= 16'(dem) << (4 * f);
    cyc(8);
    #1 chk("trip_out", exp, trip);
  endtask : vote_case

  task automatic report_and_stop;
    $display("Checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    vote_case(0, 4'h0, 4'h0, 4'h1, 4'h0, 1'b0);
    vote_case(3, 4'h0, 4'h0, 4'h9, 4'h0, 1'b1);
    vote_case(1, 4'h1, 4'h0, 4'h3, 4'h0, 1'b0);
    vote_case(2, 4'h8, 4'h0, 4'h6, 4'h0, 1'b1);
    vote_case(0, 4'h3, 4'h0, 4'h4, 4'h0, 1'b1);
    vote_case(1, 4'h3, 4'h0, 4'h3, 4'h0, 1'b0);
    vote_case(2, 4'hB, 4'h0, 4'h0, 4'h0, 1'b1);
    vote_case(3, 4'hF, 4'h0, 4'h0, 4'h0, 1'b1);
    vote_case(0, 4'h0, 4'h4, 4'hC, 4'h0, 1'b0);
    vote_case(1, 4'h0, 4'h3, 4'h4, 4'h0, 1'b1);
    vote_case(0, 4'h1, 4'h6, 4'h0, 4'h0, 1'b1);
    vote_case(0, 4'h3, 4'h0, 4'h0, 4'h1, 1'b1);
    vote_case(0, 4'h3, 4'h0, 4'h0, 4'h8, 1'b1);
    do_reset;
    svc_cmd <= 4'h1;
    cyc(8);
    dem_cmd <= 16'h0003;
    cyc(8);
    #1 chk("trip_out", 1'b0, trip);
    svc_cmd <= 4'h0;
    cyc(8);
    #1 chk("trip_out", 1'b1, trip);
    dem_cmd <= 16'h0000;
    cyc(20);
    #1 chk("trip_out", 1'b1, trip);
    do_reset;
    rd_chk("status", `TVB_OFS_STATUS, 32'h0);
    rd_chk("enable", `TVB_OFS_ENABLE, 32'h0);
    p10_cmd <= 4'hE;
    ir_req  <= 4'h3;
    prl_req <= 4'h2;
    cyc(8);
    #1 chk("ir_block_out", 4'h2, ir_blk);
    chk("prl_block_out", 4'h2, prl_blk);
    ir_req  <= 4'h0;
    prl_req <= 4'h0;
    ir_dem  <= 4'h6;
    cyc(8);
    #1 chk("ir_block_out", 4'h2, ir_blk);
    chk("trip_out", 1'b0, trip);
    p10_cmd <= 4'hC;
    cyc(3);
    #1 chk("ir_block_out", 4'h0, ir_blk);
    chk("prl_block_out", 4'h0, prl_blk);
    chk("trip_out", 1'b1, trip);
    rd_chk("status", `TVB_OFS_STATUS, 32'hD);
    rd_chk("state", `TVB_OFS_STATE, 32'h1);
    wr_reg(`TVB_OFS_CLEAR, 32'hF);
    rd_chk("status", `TVB_OFS_STATUS, 32'h0);
    wr_reg(`TVB_OFS_ENABLE, 32'h4);
    ir_req <= 4'h1;
    cyc(8);
    #1 chk("irq_out", 1'b1, irq);
    wr_reg(`TVB_OFS_ENABLE, 32'h0);
    chk("irq_out", 1'b0, irq);
    wr_reg(`TVB_OFS_ENABLE, 32'h4);
    chk("irq_out", 1'b1, irq);
    wr_reg(`TVB_OFS_CLEAR, 32'h4);
    chk("irq_out", 1'b0, irq);
    wr_reg(`TVB_OFS_STATUS, 32'hF);
    wr_reg(8'h30, 32'h0);
    rd_chk("unmapped", 8'h10, 32'h0);
    rd_chk("clear", `TVB_OFS_CLEAR, 32'h0);
    rd_chk("status", `TVB_OFS_STATUS, 32'h0);
    rd_chk("enable", `TVB_OFS_ENABLE, 32'h4);
    n_a <= {12'h100, 12'h00A, 12'h003, 12'hFFF};
    n_b <= {12'h200, 12'h00B, 12'h004, 12'h001};
    ax  <= {8{24'h5A3C71}};
    cyc(3);
    #1 chk("n16_avg_out", {12'h180, 12'h00A, 12'h003, 12'h800}, n_avg);
    chk("axial_out", {8{24'h5A3C71}}, ax_q);
    report_and_stop();
  end
endmodule : trip_vote_bypass_logic_bench
